//--- core/uswfc_params.svh
`ifndef USWFC_PARAMS_SVH
`define USWFC_PARAMS_SVH
// ----------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------
`define USWFC_IDX_IER      4'h0
`define USWFC_IDX_ISR      4'h1
`define USWFC_IDX_FCR      4'h2
`define USWFC_IDX_LCR      4'h3
`define USWFC_IDX_MCR      4'h4
`define USWFC_IDX_LSR      4'h5
`define USWFC_IDX_MSR      4'h6
`define USWFC_IDX_EFR      4'h7
`define USWFC_IDX_RES1     4'h8
`define USWFC_IDX_RES2     4'h9
`define USWFC_IDX_PAU1     4'ha
`define USWFC_IDX_PAU2     4'hb
`define USWFC_IDX_EVSTAT   4'hc
`define USWFC_IDX_EVCLR    4'hd
`define USWFC_IDX_EVEN     4'he
// ----------------------------------------
// reset values
// ----------------------------------------
`define USWFC_RST_ZERO     8'h00
`define USWFC_RST_ISR      8'h01
`define USWFC_RST_LSR      8'h60
// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define USWFC_EFR_ENH      4
`define USWFC_EFR_SPEC     5
`define USWFC_MASK_IER     8'hf0
`define USWFC_MASK_ISR     8'h30
`define USWFC_MASK_FCR     8'h30
`define USWFC_MASK_MCR     8'he0
`define USWFC_ISR_SPEC     4
`define USWFC_MCR_DTR      0
`define USWFC_MCR_RTS      1
`define USWFC_EV_SPEC      0
`define USWFC_EV_PAUSE     1
`define USWFC_EV_RESUME    2
`endif

//--- core/uswfc_pkg.sv
`default_nettype none
package uswfc_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } uswfc_char_type;
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic dcd_n;
    } uswfc_modem_type;
    typedef enum logic [1:0] {
        USWFC_FLOW_NONE,
        USWFC_FLOW_FIRST,
        USWFC_FLOW_SECOND,
        USWFC_FLOW_BOTH
    } uswfc_flow_type;
    typedef enum {
        USWFC_TX_RUN,
        USWFC_TX_HELD
    } uswfc_txst_type;
endpackage : uswfc_pkg
`default_nettype wire

//--- core/uswfc_top.sv
// Operation
// - special detect on: received char equal to second pause char flags source bit 4
// - stored char bit 0 compares against received char least significant bit
// - enhanced bit set: extended bits of four registers are writable
// - enhanced bit clear: extended bits hold their values, writes ignored
// - selection bits 3-2 choose transmit flow pair: none, first, second, both
// - selection bits 1-0 choose receive compare: 00 none, 10 first pair, 01 second pair
// - bits 1-0 both set: receiver compares both resume and both pause chars
// - reset clears enable, line, modem, fifo and enhanced control registers
// - reset clears source bits 7-1 and sets bit 0
// - reset sets line status bits 6-5, clears the rest
// - reset clears modem status deltas; upper bits read zero, pin synchronizers preset high
// - reset drives tx, rts, dtr, receive request high, transmit request and irq low
`include "uswfc_params.svh"
`default_nettype none
module uswfc_top
    import uswfc_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [5:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    input  wire uswfc_char_type  rx_char_i,
    output uswfc_char_type       rx_push_o,
    input  wire logic            tx_bit_i,
    input  wire logic            rx_fifo_avail_i,
    input  wire logic            tx_fifo_space_i,
    input  wire logic [7:0]      line_status_i,
    input  wire uswfc_modem_type modem_pins_i,
    output logic                 tx_o,
    output logic                 rts_n_o,
    output logic                 dtr_n_o,
    output logic                 receive_dma_request_n_o,
    output logic                 transmit_dma_request_n_o,
    output logic                 irq_o,
    output logic                 tx_hold_o,
    output logic      [1:0]      tx_flow_sel_o
);
    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [7:0] interrupt_enable_reg_r;
    logic [7:0] interrupt_source_reg_r;
    logic [7:0] fifo_ctrl_reg_r;
    logic [7:0] line_ctrl_reg_r;
    logic [7:0] modem_ctrl_reg_r;
    logic [7:0] line_status_reg_r;
    logic [3:0] modem_delta_r;
    logic [7:0] enhanced_feature_ctrl_r;
    logic [7:0] resume_char_first_r;
    logic [7:0] resume_char_second_r;
    logic [7:0] pause_char_first_r;
    logic [7:0] pause_char_second_r;
    logic [2:0] ev_status_r;
    logic [2:0] ev_enable_r;
    logic [31:0] dat_r;
    logic        ack_r;
    logic [3:0]  modem_s1_r;
    logic [3:0]  modem_s2_r;
    logic [3:0]  modem_s3_r;
    logic        pau1_seen_r;
    logic        res1_seen_r;
    uswfc_txst_type txst_r;
    uswfc_txst_type txst_nxt;
    uswfc_char_type push_r;
    logic        tx_r;
    logic        receive_dma_request_n_r;
    logic        transmit_dma_request_n_r;
    logic        irq_r;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        req    = wb_cyc_i & wb_stb_i;
    wire        wr_go  = req & ack_r & wb_we_i & wb_sel_i[0];
    wire        rd_go  = req & ack_r & ~wb_we_i;
    wire [3:0]  idx    = wb_adr_i[5:2];
    wire [7:0]  wd     = wb_dat_i[7:0];
    wire        enh    = enhanced_feature_ctrl_r[`USWFC_EFR_ENH];
    wire [3:0]  modem_lvl = ~modem_s2_r;
    wire [7:0]  modem_status_reg = {modem_lvl, modem_delta_r};

    function automatic logic wr_at(input logic [3:0] i);
        wr_at = wr_go && (idx == i);
    endfunction : wr_at

    // extended bits keep their value unless enhanced mode is on
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic [7:0] ext);
        merge = enh ? nw : ((old & ext) | (nw & ~ext));
    endfunction : merge

    logic [7:0] rd_mux;
    always_comb
    begin
        case (idx)
            `USWFC_IDX_IER:    rd_mux = interrupt_enable_reg_r;
            `USWFC_IDX_ISR:    rd_mux = interrupt_source_reg_r;
            `USWFC_IDX_FCR:    rd_mux = fifo_ctrl_reg_r;
            `USWFC_IDX_LCR:    rd_mux = line_ctrl_reg_r;
            `USWFC_IDX_MCR:    rd_mux = modem_ctrl_reg_r;
            `USWFC_IDX_LSR:    rd_mux = line_status_reg_r;
            `USWFC_IDX_MSR:    rd_mux = modem_status_reg;
            `USWFC_IDX_EFR:    rd_mux = enhanced_feature_ctrl_r;
            `USWFC_IDX_RES1:   rd_mux = resume_char_first_r;
            `USWFC_IDX_RES2:   rd_mux = resume_char_second_r;
            `USWFC_IDX_PAU1:   rd_mux = pause_char_first_r;
            `USWFC_IDX_PAU2:   rd_mux = pause_char_second_r;
            `USWFC_IDX_EVSTAT: rd_mux = {5'h00, ev_status_r};
            `USWFC_IDX_EVEN:   rd_mux = {5'h00, ev_enable_r};
            default:           rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------
    // flow character compare
    // ----------------------------------------
    wire [1:0] rx_sel = enhanced_feature_ctrl_r[1:0];
    wire [1:0] tx_sel = enhanced_feature_ctrl_r[3:2];
    wire [7:0] rc     = rx_char_i.data;
    wire       rv     = rx_char_i.valid;
    wire eq_p1 = (rc == pause_char_first_r);
    wire eq_p2 = (rc == pause_char_second_r);
    wire eq_r1 = (rc == resume_char_first_r);
    wire eq_r2 = (rc == resume_char_second_r);
    wire spec_en = enhanced_feature_ctrl_r[`USWFC_EFR_SPEC];
    wire spec_hit = rv & spec_en & eq_p2;

    logic pause_hit;
    logic resume_hit;
    logic flow_char;
    always_comb
    begin
        pause_hit  = 1'b0;
        resume_hit = 1'b0;
        flow_char  = 1'b0;
        case (rx_sel)
            2'b10:
            begin
                pause_hit  = rv & eq_p1;
                resume_hit = rv & eq_r1;
                flow_char  = pause_hit | resume_hit;
            end
            2'b01:
            begin
                pause_hit  = rv & eq_p2;
                resume_hit = rv & eq_r2;
                flow_char  = pause_hit | resume_hit;
            end
            2'b11:
            begin
                pause_hit  = rv & pau1_seen_r & eq_p2;
                resume_hit = rv & res1_seen_r & eq_r2;
                flow_char  = rv & (eq_p1 | eq_p2 | eq_r1 | eq_r2);
            end
            default:
            begin
                pause_hit  = 1'b0;
                resume_hit = 1'b0;
                flow_char  = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        case (txst_r)
            USWFC_TX_RUN:  txst_nxt = (pause_hit && tx_sel != 2'b00) ? USWFC_TX_HELD
                                                                     : USWFC_TX_RUN;
            USWFC_TX_HELD: txst_nxt = (resume_hit || tx_sel == 2'b00) ? USWFC_TX_RUN
                                                                       : USWFC_TX_HELD;
            default:       txst_nxt = USWFC_TX_RUN;
        endcase
    end

    // special chars are stored; flow chars are consumed
    wire push_ok = rv & (spec_hit | ~flow_char);
    wire [2:0] ev_set = {resume_hit, pause_hit, spec_hit};
    wire [2:0] ev_clr = wr_at(`USWFC_IDX_EVCLR) ? wd[2:0] : 3'h0;
    wire       isr_rd = rd_go && (idx == `USWFC_IDX_ISR);
    wire       msr_rd = rd_go && (idx == `USWFC_IDX_MSR);
    // delta bit 0 is cts and bit 3 is dcd, the reverse of the pin struct order
    wire [3:0] modem_chg_raw = modem_s2_r ^ modem_s3_r;
    wire [3:0] modem_chg     = {modem_chg_raw[0], modem_chg_raw[1], modem_chg_raw[2],
                                modem_chg_raw[3]};

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            dat_r <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            interrupt_enable_reg_r  <= `USWFC_RST_ZERO;
            fifo_ctrl_reg_r         <= `USWFC_RST_ZERO;
            line_ctrl_reg_r         <= `USWFC_RST_ZERO;
            modem_ctrl_reg_r        <= `USWFC_RST_ZERO;
            enhanced_feature_ctrl_r <= `USWFC_RST_ZERO;
        end
        else
        begin
            if (wr_at(`USWFC_IDX_IER))
                interrupt_enable_reg_r <= merge(interrupt_enable_reg_r, wd, `USWFC_MASK_IER);
            if (wr_at(`USWFC_IDX_FCR))
                fifo_ctrl_reg_r <= merge(fifo_ctrl_reg_r, wd, `USWFC_MASK_FCR);
            if (wr_at(`USWFC_IDX_MCR))
                modem_ctrl_reg_r <= merge(modem_ctrl_reg_r, wd, `USWFC_MASK_MCR);
            if (wr_at(`USWFC_IDX_LCR))
                line_ctrl_reg_r <= wd;
            if (wr_at(`USWFC_IDX_EFR))
                enhanced_feature_ctrl_r <= wd;
        end
    end

    // flow characters have no documented reset value; zero is used
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            resume_char_first_r  <= `USWFC_RST_ZERO;
            resume_char_second_r <= `USWFC_RST_ZERO;
            pause_char_first_r   <= `USWFC_RST_ZERO;
            pause_char_second_r  <= `USWFC_RST_ZERO;
        end
        else
        begin
            if (wr_at(`USWFC_IDX_RES1)) resume_char_first_r  <= wd;
            if (wr_at(`USWFC_IDX_RES2)) resume_char_second_r <= wd;
            if (wr_at(`USWFC_IDX_PAU1)) pause_char_first_r   <= wd;
            if (wr_at(`USWFC_IDX_PAU2)) pause_char_second_r  <= wd;
        end
    end

    // source reset value; set beats read clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
            interrupt_source_reg_r <= `USWFC_RST_ISR;
        else
        begin
            if (wr_at(`USWFC_IDX_ISR) && enh)
                interrupt_source_reg_r[5:4] <= wd[5:4];
            else if (isr_rd)
                interrupt_source_reg_r[`USWFC_ISR_SPEC] <= 1'b0;
            // a match in the cycle of a write or read must not be lost
            if (spec_hit)
                interrupt_source_reg_r[`USWFC_ISR_SPEC] <= 1'b1;
            interrupt_source_reg_r[0] <= ~(interrupt_source_reg_r[`USWFC_ISR_SPEC] | spec_hit);
        end
    end

    // modem deltas cleared, levels from synced pins
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            line_status_reg_r <= `USWFC_RST_LSR;
            modem_delta_r     <= 4'h0;
            modem_s1_r        <= 4'hf;
            modem_s2_r        <= 4'hf;
            modem_s3_r        <= 4'hf;
        end
        else
        begin
            line_status_reg_r <= line_status_i;
            modem_s1_r        <= modem_pins_i;
            modem_s2_r        <= modem_s1_r;
            modem_s3_r        <= modem_s2_r;
            modem_delta_r     <= modem_chg | (msr_rd ? 4'h0 : modem_delta_r);
        end
    end

    // events: set wins over clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ev_status_r <= 3'h0;
            ev_enable_r <= 3'h0;
        end
        else
        begin
            ev_status_r <= ev_set | (ev_status_r & ~ev_clr);
            if (wr_at(`USWFC_IDX_EVEN))
                ev_enable_r <= wd[2:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            txst_r      <= USWFC_TX_RUN;
            pau1_seen_r <= 1'b0;
            res1_seen_r <= 1'b0;
            push_r      <= '0;
        end
        else
        begin
            txst_r <= txst_nxt;
            if (rv)
            begin
                pau1_seen_r <= eq_p1;
                res1_seen_r <= eq_r1;
            end
            push_r.valid <= push_ok;
            push_r.data  <= rc;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tx_r      <= 1'b1;
            receive_dma_request_n_r <= 1'b1;
            transmit_dma_request_n_r <= 1'b0;
            irq_r     <= 1'b0;
        end
        else
        begin
            tx_r      <= tx_bit_i;
            receive_dma_request_n_r <= ~rx_fifo_avail_i;
            transmit_dma_request_n_r <= ~tx_fifo_space_i;
            irq_r     <= |(ev_status_r & ev_enable_r);
        end
    end

    assign wb_dat_o                 = dat_r;
    assign wb_ack_o                 = ack_r;
    assign rx_push_o                = push_r;
    assign tx_o                     = tx_r;
    assign rts_n_o                  = ~modem_ctrl_reg_r[`USWFC_MCR_RTS];
    assign dtr_n_o                  = ~modem_ctrl_reg_r[`USWFC_MCR_DTR];
    assign receive_dma_request_n_o  = receive_dma_request_n_r;
    assign transmit_dma_request_n_o = transmit_dma_request_n_r;
    assign irq_o                    = irq_r;
    assign tx_hold_o                = (txst_r == USWFC_TX_HELD);
    assign tx_flow_sel_o            = tx_sel;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_pause_taken;
        rv && pause_hit && tx_sel != 2'b00;
    endsequence
    sequence s_resume_taken;
        rv && resume_hit;
    endsequence

    a_spec_flag: assert property (@(posedge clk) disable iff (!rstn)
        spec_hit |=> interrupt_source_reg_r[4] && !interrupt_source_reg_r[0])
        else $error("special match did not raise source bit 4");
    a_spec_push: assert property (@(posedge clk) disable iff (!rstn)
        spec_hit |=> push_r.valid && push_r.data == $past(rc))
        else $error("special char not stored");
    a_ext_frozen: assert property (@(posedge clk) disable iff (!rstn)
        !enh && wr_at(4'h0) |=> interrupt_enable_reg_r[7:4] == $past(interrupt_enable_reg_r[7:4]))
        else $error("extended enable bits changed while locked");
    a_ext_open: assert property (@(posedge clk) disable iff (!rstn)
        enh && wr_at(4'h4) |=> modem_ctrl_reg_r == $past(wd))
        else $error("modem ctrl write lost in enhanced mode");
    a_hold_set: assert property (@(posedge clk) disable iff (!rstn)
        s_pause_taken ##1 !resume_hit |-> tx_hold_o)
        else $error("pause did not hold transmit");
    a_hold_free: assert property (@(posedge clk) disable iff (!rstn)
        tx_hold_o ##0 s_resume_taken |=> !tx_hold_o)
        else $error("resume did not release transmit");
    a_none_nohold: assert property (@(posedge clk) disable iff (!rstn)
        rx_sel == 2'b00 |-> !pause_hit && !resume_hit)
        else $error("compare active with receive flow off");
    a_both_seq: assert property (@(posedge clk) disable iff (!rstn)
        rx_sel == 2'b11 && pause_hit |-> $past(rv && eq_p1, 1) || pau1_seen_r)
        else $error("pause pair matched without first char");
    a_flow_drop: assert property (@(posedge clk) disable iff (!rstn)
        rv && flow_char && !spec_hit |=> !push_r.valid)
        else $error("flow char pushed to fifo");
    a_reset_pins: assert property (@(posedge clk)
        !rstn |=> tx_o && rts_n_o && dtr_n_o && receive_dma_request_n_o
                  && !transmit_dma_request_n_o && !irq_o)
        else $error("reset pin levels wrong");
    a_reset_regs: assert property (@(posedge clk)
        !rstn |=> interrupt_source_reg_r == 8'h01 && line_status_reg_r == 8'h60
                  && modem_delta_r == 4'h0 && enhanced_feature_ctrl_r == 8'h00)
        else $error("reset register values wrong");
    a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
        |(ev_status_r & ev_enable_r) |=> irq_o)
        else $error("enabled event did not raise irq");
endmodule : uswfc_top
`default_nettype wire

//--- verif/tb.sv
`include "uswfc_params.svh"
`default_nettype none
// ----------------------------------------
// testbench
// ----------------------------------------
module tb
    import uswfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk, rstn, cyc, stb, we, ack, txb, rxav, txsp;
    logic [5:0]      adr;
    logic [3:0]      sel;
    logic [31:0]     wdat, rdat;
    logic [7:0]      lsi, q;
    logic            tx, rts_n, dtr_n, rdma_n, tdma_n, irq, hold;
    logic [1:0]      fsel;
    uswfc_char_type  rxc, push;
    uswfc_modem_type mp;
    int              mismatches, tests_run;
    logic [7:0]      rexp [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00};

    uswfc_top uswfc_top_i (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rx_char_i(rxc), .rx_push_o(push), .tx_bit_i(txb),
        .rx_fifo_avail_i(rxav), .tx_fifo_space_i(txsp), .line_status_i(lsi),
        .modem_pins_i(mp), .tx_o(tx), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
        .receive_dma_request_n_o(rdma_n), .transmit_dma_request_n_o(tdma_n),
        .irq_o(irq), .tx_hold_o(hold), .tx_flow_sel_o(fsel));
    uswfc_remote uswfc_remote_i (.clk(clk), .rx_char_o(rxc));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h000000, d};
        n = 0;
        // no latency assumed; the bound only catches a dead slave
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            chk("ack", 1'b0, 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), q, exp);
    endtask : rd

    task automatic rx(input logic [7:0] d, input logic ep, input logic eh);
        uswfc_remote_i.send(d);
        #1;
        chk("push_valid", push.valid, ep);
        if (ep)
            chk("push_data", push.data, d);
        chk("tx_hold", hold, eh);
    endtask : rx

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        {rstn, cyc, stb, we, adr, sel, wdat, txb, txsp} = '0;
        rxav = 1'b1;
        lsi = 8'h60;
        mp = '{1'b1, 1'b1, 1'b1, 1'b1};
        mismatches = 0;
        tests_run = 0;
        repeat (4) @(posedge clk);
        #1;
        chk("reset_outs", {tx, rts_n, dtr_n, rdma_n, tdma_n, irq, hold}, 7'b1111000);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("run_outs", {tx, rdma_n, tdma_n}, 3'b001);
        for (int i = 0; i < 8; i++)
            rd(i[3:0], rexp[i]);
        rd(4'hf, 8'h00);
        lsi <= 8'h1e;
        mp <= '{1'b0, 1'b1, 1'b1, 1'b1};
        repeat (4) @(posedge clk);
        rd(`USWFC_IDX_LSR, 8'h1e);
        rd(`USWFC_IDX_MSR, 8'h81);
        $display("test reset done");

        wb(1'b1, `USWFC_IDX_IER, 8'hff);
        rd(`USWFC_IDX_IER, 8'h0f);
        wb(1'b1, `USWFC_IDX_EFR, 8'h10);
        wb(1'b1, `USWFC_IDX_IER, 8'hff);
        rd(`USWFC_IDX_IER, 8'hff);
        wb(1'b1, `USWFC_IDX_MCR, 8'he3);
        rd(`USWFC_IDX_MCR, 8'he3);
        chk("rts_dtr", {rts_n, dtr_n}, 2'b00);
        wb(1'b1, `USWFC_IDX_EFR, 8'h00);
        wb(1'b1, `USWFC_IDX_IER, 8'h00);
        rd(`USWFC_IDX_IER, 8'hf0);
        wb(1'b1, `USWFC_IDX_MCR, 8'h00);
        rd(`USWFC_IDX_MCR, 8'he0);
        chk("rts_dtr", {rts_n, dtr_n}, 2'b11);
        $display("test lock done");

        wb(1'b1, `USWFC_IDX_RES1, 8'h11);
        wb(1'b1, `USWFC_IDX_RES2, 8'h91);
        wb(1'b1, `USWFC_IDX_PAU1, 8'h13);
        wb(1'b1, `USWFC_IDX_PAU2, 8'h93);
        wb(1'b1, `USWFC_IDX_EFR, 8'h0a);
        #1;
        chk("flow_sel", fsel, 2'b10);
        rx(8'hc8, 1'b1, 1'b0);
        rx(8'h13, 1'b0, 1'b1);
        rx(8'h11, 1'b0, 1'b0);
        wb(1'b1, `USWFC_IDX_EFR, 8'h05);
        #1;
        chk("flow_sel", fsel, 2'b01);
        rx(8'h13, 1'b1, 1'b0);
        rx(8'h93, 1'b0, 1'b1);
        rx(8'h91, 1'b0, 1'b0);
        wb(1'b1, `USWFC_IDX_EFR, 8'h0f);
        #1;
        chk("flow_sel", fsel, 2'b11);
        uswfc_remote_i.send(8'h13);
        rx(8'h93, 1'b0, 1'b1);
        uswfc_remote_i.send(8'h11);
        rx(8'h91, 1'b0, 1'b0);
        wb(1'b1, `USWFC_IDX_EFR, 8'h02);
        rx(8'h13, 1'b0, 1'b0);
        $display("test flow done");

        wb(1'b1, `USWFC_IDX_EVCLR, 8'h07);
        wb(1'b1, `USWFC_IDX_EVEN, 8'h00);
        // special detect tested here with every flow selection bit cleared
        wb(1'b1, `USWFC_IDX_EFR, 8'h20);
        rx(8'h13, 1'b1, 1'b0);
        rd(`USWFC_IDX_ISR, 8'h01);
        rx(8'h93, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        rd(`USWFC_IDX_ISR, 8'h10);
        chk("irq_masked", irq, 1'b0);
        repeat (2) @(posedge clk);
        rd(`USWFC_IDX_ISR, 8'h01);
        rd(`USWFC_IDX_EVSTAT, 8'h01);
        wb(1'b1, `USWFC_IDX_EVEN, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_on", irq, 1'b1);
        wb(1'b1, `USWFC_IDX_EVCLR, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_off", irq, 1'b0);
        rd(`USWFC_IDX_EVSTAT, 8'h00);
        $display("test special done");
        results();
    end
endmodule : tb
`default_nettype wire

//--- verif/uswfc_remote.sv
`default_nettype none
// ----------------------------------------
// remote serial station
// ----------------------------------------
module uswfc_remote
    import uswfc_pkg::*;
(
    input  wire logic      clk,
    output uswfc_char_type rx_char_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_char_o = '{1'b0, 8'h00};
    // flow chars kept apart
    // data bytes never equal a flow char of the selected pair; the bench picks them that way
    task automatic send(input logic [7:0] d);
        @(posedge clk);
        rx_char_o <= '{1'b1, d};
        @(posedge clk);
        // released byte inverted so a stale value can never match twice
        rx_char_o <= '{1'b0, ~d};
    endtask : send
endmodule : uswfc_remote
`default_nettype wire
